// file: logic/icx_pkg.sv
/*
  Shared constants for the two-level interrupt controller: special register
  addresses, bit positions, machine-cycle timing and source numbering.
  Assumes the CPU core and the flag sources run on the same clock.
*/
package icx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Special register space addresses and widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE_MASK = 8'hA8;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL_SELECT = 8'hB8;
  localparam logic [DATA_W-1:0] ENABLE_MASK_RST = 8'h00;
  localparam logic [DATA_W-1:0] LEVEL_SELECT_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions, shared by both registers for the source bits
  localparam int unsigned BIT_GLOBAL_GATE = 7;
  localparam int unsigned BIT_LEVEL_LOGIC_STOP = 7;
  localparam int unsigned BIT_RESERVED = 6;
  localparam int unsigned MAX_SRC = 6;
  localparam int unsigned IDX_W = 3;

  // Source index, equal to the bit position and to the polling rank
  localparam logic [IDX_W-1:0] SRC_EXT0 = 3'h0;
  localparam logic [IDX_W-1:0] SRC_TIMER0 = 3'h1;
  localparam logic [IDX_W-1:0] SRC_EXT1 = 3'h2;
  localparam logic [IDX_W-1:0] SRC_TIMER1 = 3'h3;
  localparam logic [IDX_W-1:0] SRC_SERIAL = 3'h4;
  localparam logic [IDX_W-1:0] SRC_TIMER2 = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Machine cycle: six states of two oscillator periods each
  localparam int unsigned STATES_PER_CYCLE = 6;
  localparam int unsigned PERIODS_PER_STATE = 2;
  localparam int unsigned TICKS_PER_CYCLE = STATES_PER_CYCLE * PERIODS_PER_STATE;
  localparam int unsigned TICK_W = 4;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICKS_PER_CYCLE - 1);
  localparam logic [TICK_W-1:0] TICK_ZERO = 4'h0;
  // Sample at the end of state 5, poll in state 1 of the next cycle
  localparam logic [TICK_W-1:0] TICK_SAMPLE = TICK_W'(5 * PERIODS_PER_STATE - 1);
  localparam logic [TICK_W-1:0] TICK_POLL = TICK_W'(PERIODS_PER_STATE - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Call handshake states
  typedef enum logic [1:0] {
    ICX_IDLE = 2'b01,
    ICX_CALL = 2'b10
  } icx_state_t;

endpackage

// file: logic/icx_poll_pick.sv
/*
  Fixed polling order picker: the lowest-numbered set request wins.
  Assumes requests are already gated by enables and level; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module icx_poll_pick
#(
  parameter int unsigned NUM_SRC = 6
)
(
  input wire logic [NUM_SRC-1:0] req, // Gated requests of one level
  output logic any, // At least one request present
  output logic [icx_pkg::IDX_W-1:0] idx // Winning source index
);
  import icx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Scan from last to first so the first in order is left standing
  always_comb
  begin
    any = 1'b0;
    idx = SRC_EXT0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        any = 1'b1;
        idx = IDX_W'(i);
      end
    end
  end

endmodule
`default_nettype wire

// file: logic/icx_ctrl.sv
/*
  Two-level interrupt controller: enable and level registers in the special
  register space, machine-cycle sampling, polling and the long-call request.
  Assumes the CPU sequencer pushes only the program counter on callAck and
  pulses returnFromService when it executes the return-from-service opcode.
*/
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Five sources, plus a sixth for the third timer when present.
// - Each source has its own enable bit; disabled sources never serviced.
// - Enable bit 7 gates everything; zero blocks all acknowledgement.
// - Enable bits: 5 timer2, 4 serial, 3 timer1, 2 ext1, 1 timer0, 0 ext0.
// - Level register uses same bit positions; one means high level.
// - Level bit 7 set stops level logic; only enables then matter.
// - Low service in progress admits high requests, blocks other low ones.
// - High service in progress blocks every other request.
// - High-level request wins over low-level in the same poll.
// - Same-level requests resolved by a fixed polling order.
// - All flags captured into samples during state 5 of each cycle.
// - Next cycle polls samples and requests a long call if unblocked.
// - No vectoring while equal or higher level service is running.
// - Call pushes program counter and loads the source's fixed vector.
// - Only program counter saved by hardware; status word left to software.
// - Return from service clears in-progress state of the active level.
// - Return with nothing in progress changes no controller state.
// - Machine cycle is six states of two periods each.
module icx_ctrl
#(
  parameter int unsigned NUM_SRC = 6, // Five, or six with a third timer
  parameter bit HAS_LEVEL_STOP = 1'b1, // Level register bit 7 implemented
  parameter logic [15:0] VEC_BASE = 16'h0003, // Vector of first source
  parameter logic [15:0] VEC_STRIDE = 16'h0008 // Distance between vectors
)
(
  input wire logic clk_sys, // Oscillator clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic clkEn, // Freezes all state but the reset synchronizer while low
  input wire logic [icx_pkg::ADDR_W-1:0] sfrAddr, // Special register address
  input wire logic sfrWrEn, // Write strobe
  input wire logic [icx_pkg::DATA_W-1:0] sfrWrData, // Write data
  input wire logic sfrRdEn, // Read strobe
  output logic [icx_pkg::DATA_W-1:0] sfrRdData, // Read data, registered
  input wire logic [NUM_SRC-1:0] reqFlag, // Peripheral request flags
  input wire logic callBlock, // Sequencer cannot take a call now
  input wire logic callAck, // Sequencer starts the long call
  input wire logic returnFromService, // Return opcode executed, pulse
  output logic longCallReq, // Long call wanted, held until ack
  output logic [15:0] vectorAddr, // Start address for the call
  output logic [icx_pkg::IDX_W-1:0] srcServiced, // Source being called
  output logic callLevelHigh, // Call is of the high level
  output logic inProgHigh, // High-level service running
  output logic inProgLow, // Low-level service running
  output logic [icx_pkg::TICK_W-1:0] cycleTick // Position in machine cycle
);
  import icx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic [1:0] rstSync_q;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rstSync_q <= 2'b00;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rst_n = rstSync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [DATA_W-1:0] enMask_q, enMask_d;
  logic [DATA_W-1:0] lvlSel_q, lvlSel_d;
  logic [DATA_W-1:0] rdData_q, rdData_d;
  logic [TICK_W-1:0] tick_q, tick_d;
  logic [NUM_SRC-1:0] sample_q, sample_d;
  logic [NUM_SRC-1:0] pendHigh, pendLow;
  logic anyHigh, anyLow;
  logic [IDX_W-1:0] idxHigh, idxLow;
  logic levelStop, pollNow, takeHigh, takeLow, retDone;
  icx_state_t state_q, state_d;
  logic callReq_q, callReq_d;
  logic callHigh_q, callHigh_d;
  logic [IDX_W-1:0] srcIdx_q, srcIdx_d;
  logic [15:0] vec_q, vec_d;
  logic progHigh_q, progHigh_d;
  logic progLow_q, progLow_d;

  ////////////////////////////////////////////////////////////////////////////
  // Register access; bit 6 is not stored so it always reads zero
  always_comb
  begin
    enMask_d = enMask_q;
    lvlSel_d = lvlSel_q;
    rdData_d = rdData_q;
    if (sfrWrEn && sfrAddr == ADDR_ENABLE_MASK)
    begin
      enMask_d = sfrWrData;
      enMask_d[BIT_RESERVED] = 1'b0;
    end
    if (sfrWrEn && sfrAddr == ADDR_LEVEL_SELECT)
    begin
      lvlSel_d = sfrWrData;
      lvlSel_d[BIT_RESERVED] = 1'b0;
      lvlSel_d[BIT_LEVEL_LOGIC_STOP] = HAS_LEVEL_STOP & sfrWrData[BIT_LEVEL_LOGIC_STOP];
    end
    // Unused source bits stay zero on a five-source build
    for (int i = NUM_SRC; i < MAX_SRC; i++)
    begin
      enMask_d[i] = 1'b0;
      lvlSel_d[i] = 1'b0;
    end
    if (sfrRdEn)
    begin
      // Unmapped addresses read as zero rather than stale data
      unique case (sfrAddr)
        ADDR_ENABLE_MASK: rdData_d = enMask_q;
        ADDR_LEVEL_SELECT: rdData_d = lvlSel_q;
        default: rdData_d = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Machine-cycle position and flag sampling
  always_comb
  begin
    tick_d = (tick_q == TICK_LAST) ? TICK_ZERO : tick_q + 4'h1;
    sample_d = (tick_q == TICK_SAMPLE) ? reqFlag : sample_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-source gating; level logic stopped puts everyone on the low level
  assign levelStop = HAS_LEVEL_STOP & lvlSel_q[BIT_LEVEL_LOGIC_STOP];

  for (genvar g = 0; g < NUM_SRC; g++)
  begin : gSrc
    logic live;
    assign live = sample_q[g] & enMask_q[g] & enMask_q[BIT_GLOBAL_GATE];
    assign pendHigh[g] = live & lvlSel_q[g] & ~levelStop;
    assign pendLow[g] = live & ~(lvlSel_q[g] & ~levelStop);
  end

  icx_poll_pick #(.NUM_SRC(NUM_SRC)) uPickHigh
  (
    .req(pendHigh),
    .any(anyHigh),
    .idx(idxHigh)
  );

  icx_poll_pick #(.NUM_SRC(NUM_SRC)) uPickLow
  (
    .req(pendLow),
    .any(anyLow),
    .idx(idxLow)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Poll once per machine cycle, in state 1 of the cycle after the samples were taken
  assign pollNow = (state_q == ICX_IDLE) && (tick_q == TICK_POLL) && !callBlock;
  assign takeHigh = pollNow && anyHigh && !progHigh_q;
  assign takeLow = pollNow && anyLow && !anyHigh && !progHigh_q && !progLow_q;

  // Call handshake; request stands until the sequencer accepts it
  always_comb
  begin
    state_d = state_q;
    callReq_d = callReq_q;
    callHigh_d = callHigh_q;
    srcIdx_d = srcIdx_q;
    vec_d = vec_q;
    unique case (state_q)
      ICX_IDLE:
      begin
        if (takeHigh || takeLow)
        begin
          state_d = ICX_CALL;
          callReq_d = 1'b1;
          callHigh_d = takeHigh;
          srcIdx_d = takeHigh ? idxHigh : idxLow;
          vec_d = 16'(VEC_BASE + 16'(srcIdx_d) * VEC_STRIDE);
        end
      end
      ICX_CALL:
      begin
        // Sequencer pushes only the program counter here
        if (callAck)
        begin
          state_d = ICX_IDLE;
          callReq_d = 1'b0;
        end
      end
      default:
      begin
        state_d = ICX_IDLE;
        callReq_d = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // In-progress levels: return clears the higher active one, a new call sets
  always_comb
  begin
    progHigh_d = progHigh_q;
    progLow_d = progLow_q;
    retDone = returnFromService && (progHigh_q || progLow_q);
    if (retDone)
    begin
      if (progHigh_q)
        progHigh_d = 1'b0;
      else
        progLow_d = 1'b0;
    end
    // Set after clear so a call in the same cycle is never lost
    if (state_q == ICX_CALL && callAck)
    begin
      if (callHigh_q)
        progHigh_d = 1'b1;
      else
        progLow_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enMask_q <= ENABLE_MASK_RST;
      lvlSel_q <= LEVEL_SELECT_RST;
      rdData_q <= '0;
      tick_q <= TICK_ZERO;
      sample_q <= '0;
      state_q <= ICX_IDLE;
      callReq_q <= 1'b0;
      callHigh_q <= 1'b0;
      srcIdx_q <= SRC_EXT0;
      vec_q <= '0;
      progHigh_q <= 1'b0;
      progLow_q <= 1'b0;
    end
    else if (clkEn)
    begin
      enMask_q <= enMask_d;
      lvlSel_q <= lvlSel_d;
      rdData_q <= rdData_d;
      tick_q <= tick_d;
      sample_q <= sample_d;
      state_q <= state_d;
      callReq_q <= callReq_d;
      callHigh_q <= callHigh_d;
      srcIdx_q <= srcIdx_d;
      vec_q <= vec_d;
      progHigh_q <= progHigh_d;
      progLow_q <= progLow_d;
    end
  end

  // Outputs straight from flops
  assign sfrRdData = rdData_q;
  assign longCallReq = callReq_q;
  assign vectorAddr = vec_q;
  assign srcServiced = srcIdx_q;
  assign callLevelHigh = callHigh_q;
  assign inProgHigh = progHigh_q;
  assign inProgLow = progLow_q;
  assign cycleTick = tick_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_gate;
    @(posedge clk_sys) disable iff (!rst_n)
    (clkEn && pollNow && !enMask_q[BIT_GLOBAL_GATE]) |=> !callReq_q;
  endproperty
  a_gate: assert property (p_gate) else $error("call despite global gate off");

  property p_srcEnabled;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(callReq_q)
      |-> |($past(enMask_q[NUM_SRC-1:0] & sample_q) & (NUM_SRC'(1) << srcIdx_q));
  endproperty
  a_srcEnabled: assert property (p_srcEnabled) else $error("disabled source called");

  property p_highBlocks;
    @(posedge clk_sys) disable iff (!rst_n)
    (clkEn && state_q == ICX_IDLE && progHigh_q) |=> !callReq_q;
  endproperty
  a_highBlocks: assert property (p_highBlocks) else $error("call during high service");

  property p_lowPreempt;
    @(posedge clk_sys) disable iff (!rst_n)
    ($rose(callReq_q) && $past(progLow_q)) |-> callHigh_q;
  endproperty
  a_lowPreempt: assert property (p_lowPreempt) else $error("low call nested in low");

  property p_highFirst;
    @(posedge clk_sys) disable iff (!rst_n)
    (clkEn && pollNow && anyHigh && anyLow && !progHigh_q) |=> callReq_q && callHigh_q;
  endproperty
  a_highFirst: assert property (p_highFirst) else $error("high request not first");

  property p_sample;
    @(posedge clk_sys) disable iff (!rst_n)
    (clkEn && tick_q == TICK_SAMPLE) |=> sample_q == $past(reqFlag);
  endproperty
  a_sample: assert property (p_sample) else $error("flags not sampled in state 5");

  property p_vector;
    @(posedge clk_sys) disable iff (!rst_n)
    callReq_q |-> vec_q == 16'(VEC_BASE + 16'(srcIdx_q) * VEC_STRIDE);
  endproperty
  a_vector: assert property (p_vector) else $error("vector does not match source");

  property p_retClear;
    @(posedge clk_sys) disable iff (!rst_n)
    (clkEn && returnFromService && progHigh_q && !(state_q == ICX_CALL && callAck))
      |=> !progHigh_q && $stable(progLow_q);
  endproperty
  a_retClear: assert property (p_retClear) else $error("return left high level set");

  property p_retIdle;
    @(posedge clk_sys) disable iff (!rst_n)
    (clkEn && returnFromService && !progHigh_q && !progLow_q && state_q == ICX_IDLE)
      |=> !progHigh_q && !progLow_q;
  endproperty
  a_retIdle: assert property (p_retIdle) else $error("idle return changed state");

  property p_cycle;
    @(posedge clk_sys) disable iff (!rst_n)
    (clkEn && tick_q == TICK_LAST) |=> tick_q == TICK_ZERO;
  endproperty
  a_cycle: assert property (p_cycle) else $error("machine cycle length wrong");

endmodule
`default_nettype wire

// file: tb/icx_cpu_model.sv
/*
  Sequencer stand-in: takes each long call after a set delay and keeps
  the target it loaded. Assumes the controller shares its clock.
*/
`timescale 1ns/1ps
`default_nettype none
module icx_cpu_model
(
  input wire logic clk_sys, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic longCallReq, // Call wanted
  input wire logic [15:0] vectorAddr, // Call target
  input wire logic [3:0] ackDelay, // Cycles before taking a call
  output logic callAck, // Call taken, one-cycle pulse
  output logic [15:0] lastVec // Target of the last call
);
  logic [3:0] waitQ;

  ////////////////////////////////////////////////////////////////////////
  // Slow delays catch a design that drops its request before the ack
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waitQ <= 4'h0;
      callAck <= 1'b0;
      lastVec <= 16'h0000;
    end
    else if (longCallReq && !callAck && waitQ == ackDelay)
    begin
      callAck <= 1'b1;
      lastVec <= vectorAddr;
      waitQ <= 4'h0;
    end
    else
    begin
      callAck <= 1'b0;
      waitQ <= (longCallReq && !callAck) ? waitQ + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// file: tb/icx_ctrl_tb_top.sv
/*
  Self-checking bench for the interrupt controller with a sequencer model.
  Assumes default vectors and all six sources present.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      errorCnt++; \
      $display("[FAIL] %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module icx_ctrl_tb_top;
  logic clk_sys, arst_n, clkEn, sfrWrEn, sfrRdEn, callBlock, callAck;
  logic returnFromService, longCallReq, callLevelHigh, inProgHigh, inProgLow;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, d;
  logic [5:0] reqFlag;
  logic [15:0] vectorAddr, lastVec;
  logic [2:0] srcServiced;
  logic [3:0] cycleTick, ackDelay, t;
  logic seen;
  int errorCnt = 0;
  int compares = 0;

  icx_ctrl #(.NUM_SRC(6)) u_icx_ctrl (.clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn),
    .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
    .sfrRdData(sfrRdData), .reqFlag(reqFlag), .callBlock(callBlock), .callAck(callAck),
    .returnFromService(returnFromService), .longCallReq(longCallReq),
    .vectorAddr(vectorAddr), .srcServiced(srcServiced), .callLevelHigh(callLevelHigh),
    .inProgHigh(inProgHigh), .inProgLow(inProgLow), .cycleTick(cycleTick));
  icx_cpu_model u_icx_cpu_model (.clk_sys(clk_sys), .arst_n(arst_n),
    .longCallReq(longCallReq), .vectorAddr(vectorAddr), .ackDelay(ackDelay),
    .callAck(callAck), .lastVec(lastVec));

  ////////////////////////////////////////////////////////////////////////
  // Bus and call helpers
  task automatic wrapUp();
    $display("Errors %0d, compares %0d", errorCnt, compares);
    if (errorCnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic sfrWr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    sfrAddr <= a;
    sfrWrData <= v;
    sfrWrEn <= 1'b1;
    @(posedge clk_sys);
    sfrWrEn <= 1'b0;
  endtask
  // Read data stands until the next read, so a late look is safe
  task automatic sfrRd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge clk_sys);
    sfrRdEn <= 1'b0;
    @(posedge clk_sys);
    #1;
    v = sfrRdData;
  endtask
  task automatic setFlags(input logic [5:0] v);
    @(posedge clk_sys);
    reqFlag <= v;
  endtask
  task automatic noCall(output logic s);
    s = 1'b0;
    repeat (30)
    begin
      @(posedge clk_sys);
      #1;
      if (longCallReq === 1'b1)
        s = 1'b1;
    end
  endtask
  task automatic retPulse();
    @(posedge clk_sys);
    returnFromService <= 1'b1;
    @(posedge clk_sys);
    returnFromService <= 1'b0;
    #1;
  endtask
  // Waits for a call, checks it, lets the model take it, drops the flag
  task automatic getCall(input logic [2:0] idx, input logic hi);
    int n;
    n = 0;
    #1;
    while (longCallReq !== 1'b1 && n < 40)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK("call wait", longCallReq, 1'b1)
    if (longCallReq !== 1'b1)
      wrapUp();
    else
    begin
      if (n > 0)
        `CHK("tick", cycleTick, 4'h2)
      `CHK("src", srcServiced, idx)
      `CHK("level", callLevelHigh, hi)
      `CHK("vector", vectorAddr, 16'h0003 + 16'(idx) * 16'h0008)
      n = 0;
      while (longCallReq === 1'b1 && n < 20)
      begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      `CHK("ack wait", longCallReq, 1'b0)
      if (longCallReq !== 1'b0)
        wrapUp();
      else
      begin
        `CHK("loaded", lastVec, 16'h0003 + 16'(idx) * 16'h0008)
        `CHK("inprog", hi ? inProgHigh : inProgLow, 1'b1)
        @(posedge clk_sys);
        reqFlag[idx] <= 1'b0;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock, reset and scenarios
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Register reset values, stored bits and unmapped reads
  task automatic scnRegs();
    sfrRd(8'hA8, d);
    `CHK("mask reset", d, 8'h00)
    sfrRd(8'hB8, d);
    `CHK("level reset", d, 8'h00)
    sfrWr(8'hA8, 8'hFF);
    sfrRd(8'hA8, d);
    `CHK("mask bits", d, 8'hBF)
    sfrWr(8'hB8, 8'hFF);
    sfrRd(8'hB8, d);
    `CHK("level bits", d, 8'hBF)
    sfrRd(8'h99, d);
    `CHK("unmapped", d, 8'h00)
  endtask
  // Machine cycle wraps after twelve ticks and freezes without clkEn
  task automatic scnCycle();
    int n;
    n = 0;
    while (cycleTick !== 4'hB && n < 20)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK("last tick", cycleTick, 4'hB)
    if (cycleTick !== 4'hB)
      wrapUp();
    else
    begin
      @(posedge clk_sys);
      #1;
      `CHK("wrap", cycleTick, 4'h0)
      @(posedge clk_sys);
      clkEn <= 1'b0;
      #1;
      t = cycleTick;
      repeat (3) @(posedge clk_sys);
      `CHK("freeze", cycleTick, t)
      clkEn <= 1'b1;
    end
  endtask
  // Gate off, then every source off, then sequencer busy
  task automatic scnBlocked();
    sfrWr(8'hB8, 8'h00);
    sfrWr(8'hA8, 8'h3F);
    setFlags(6'h3F);
    noCall(seen);
    `CHK("gate", seen, 1'b0)
    sfrWr(8'hA8, 8'h80);
    noCall(seen);
    `CHK("src off", seen, 1'b0)
    @(posedge clk_sys);
    callBlock <= 1'b1;
    sfrWr(8'hA8, 8'hBF);
    noCall(seen);
    `CHK("blocked", seen, 1'b0)
    @(posedge clk_sys);
    callBlock <= 1'b0;
  endtask
  // All six pending at low level: served strictly in polling order
  task automatic scnPollOrder();
    for (int i = 0; i < 6; i++)
    begin
      getCall(3'(i), 1'b0);
      if (i == 0)
      begin
        noCall(seen);
        `CHK("low blocks low", seen, 1'b0)
      end
      retPulse();
      `CHK("low done", inProgLow, 1'b0)
    end
    retPulse();
    `CHK("idle ret", {inProgHigh, inProgLow}, 2'b00)
  endtask
  // Serial at high level, with a slow sequencer, then nested in low
  task automatic scnHigh();
    @(posedge clk_sys);
    ackDelay <= 4'h3;
    sfrWr(8'hB8, 8'h10);
    setFlags(6'h11);
    getCall(3'h4, 1'b1);
    noCall(seen);
    `CHK("high blocks", seen, 1'b0)
    retPulse();
    `CHK("high done", inProgHigh, 1'b0)
    getCall(3'h0, 1'b0);
    setFlags(6'h10);
    getCall(3'h4, 1'b1);
    retPulse();
    `CHK("nested", {inProgHigh, inProgLow}, 2'b01)
    retPulse();
    `CHK("outer", inProgLow, 1'b0)
  endtask
  // Level logic stopped: polling order alone decides
  task automatic scnLevelStop();
    sfrWr(8'hB8, 8'h90);
    setFlags(6'h11);
    getCall(3'h0, 1'b0);
    retPulse();
    getCall(3'h4, 1'b0);
    retPulse();
    `CHK("stop done", {inProgHigh, inProgLow}, 2'b00)
  endtask

  initial
  begin
    arst_n = 1'b0;
    clkEn = 1'b1;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    sfrWrEn = 1'b0;
    sfrRdEn = 1'b0;
    reqFlag = 6'h00;
    callBlock = 1'b0;
    returnFromService = 1'b0;
    ackDelay = 4'h0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    scnRegs();
    scnCycle();
    scnBlocked();
    scnPollOrder();
    scnHigh();
    scnLevelStop();
    wrapUp();
  end
endmodule
`default_nettype wire
